// ==== hdl/crcg_byte_step.sv ====
// Purpose: Combinational step of eight message bits into the CRC
// Assumes: Message bits enter most significant first
// Notes: Unrolled by a generate chain, no state
`timescale 1ns/1ns
module crcg_byte_step #(
	parameter int W = 16,
	parameter int N = 8,
	parameter logic [15:0] POLY = 16'h1021
) (
	input wire logic [W-1:0] crc_in,
	input wire logic [N-1:0] data_in,
	output logic [W-1:0] crc_out
);
	// Elaboration check
	if (W != 16) begin : g_bad_w
		$error("crcg_byte_step supports a 16-bit register only");
	end
	logic [W-1:0] stage [0:N];
	assign stage[0] = crc_in;
	// One bit per stage, feedback taps from the polynomial
	for (genvar i = 0; i < N; i++) begin : g_bit
		wire fb = stage[i][W-1] ^ data_in[N-1-i]; // [R8]
		assign stage[i+1] = {stage[i][W-2:0], 1'b0} ^
			(fb ? POLY : 16'h0000); // [R2]
	end
	assign crc_out = stage[N];
endmodule

// ==== hdl/crcg_top.sv ====
// Purpose: CRC16 generator with byte ports for high and low halves
// Assumes: Write strobes come from logic on clk_sys
// Notes: Reads have no side effects; results valid cycle after write
`timescale 1ns/1ns
// Overview of operation
// [R1] Running result lives in a sixteen-bit shift register.
// [R2] Feedback taps follow x^16 + x^12 + x^5 + 1.
// [R3] CRC16 detects single, double, odd and most burst errors.
// [R4] Wait mode behaves exactly like run mode.
// [R5] Deep stop modes halt and return the generator to reset.
// [R6] Light stop mode freezes state and resumes unchanged afterward.
// [R7] High write loads bits 15-8, next low write loads bits 7-0.
// [R8] Later low writes shift eight data bits in, MSB first.
// [R9] Byte shift completes by the cycle after its write.
// [R10] Port reads return result halves directly, no side effects.
// [R11] Reset clears result and seed sequencing to data mode.
module crcg_top (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire crcg_pkg::crcg_pmode_t pmode,
	input wire logic wr_high,
	input wire logic wr_low,
	input wire logic [crcg_pkg::BYTE_W-1:0] wr_data,
	output logic [crcg_pkg::BYTE_W-1:0] crc_high_byte_port,
	output logic [crcg_pkg::BYTE_W-1:0] crc_low_byte_port
);
	import crcg_pkg::*;

	// ************************************************
	// Helper functions
	// ************************************************
	// Byte halves of a result word, shared by update and ports
	function automatic logic [BYTE_W-1:0] hi_half(
		input logic [CRC_W-1:0] v
	);
		return v[CRC_W-1:HI_LSB];
	endfunction
	function automatic logic [BYTE_W-1:0] lo_half(
		input logic [CRC_W-1:0] v
	);
		return v[HI_LSB-1:LO_LSB];
	endfunction

	// ************************************************
	// Power mode decode
	// ************************************************
	wire deep_stop = (pmode == CRCG_STOP_DEEP); // [R5]
	wire frozen = (pmode == CRCG_STOP_LIGHT); // [R6]
	wire active = !deep_stop && !frozen; // [R4]

	// ************************************************
	// State
	// ************************************************
	logic [CRC_W-1:0] crc_r, crc_nxt; // [R1]
	crcg_seq_t seq_r, seq_nxt;
	logic [CRC_W-1:0] stepped;

	crcg_byte_step #(
		.W(CRC_W),
		.N(BYTE_W),
		.POLY(CRC_POLY)
	) u_step (
		.crc_in(crc_r),
		.data_in(wr_data),
		.crc_out(stepped)
	);

	// Constant term keeps every single-bit flip visible
	if (CRC_POLY[0] != 1'b1) begin : g_bad_poly
		$error("polynomial lacks its constant term"); // [R3]
	end

	// Next-state selection
	wire do_hi = active && wr_high;
	wire do_seed_lo = active && !wr_high && wr_low &&
		(seq_r == CRCG_SEQ_SEED_LO);
	wire do_data = active && !wr_high && wr_low &&
		(seq_r == CRCG_SEQ_DATA);
	always_comb begin
		crc_nxt = crc_r;
		seq_nxt = seq_r;
		if (deep_stop) begin
			crc_nxt = CRC_RESET_VAL; // [R5]
			seq_nxt = CRCG_SEQ_DATA;
		end else if (do_hi) begin
			crc_nxt = {wr_data, lo_half(crc_r)}; // [R7]
			seq_nxt = CRCG_SEQ_SEED_LO;
		end else if (do_seed_lo) begin
			crc_nxt = {hi_half(crc_r), wr_data}; // [R7]
			seq_nxt = CRCG_SEQ_DATA;
		end else if (do_data) begin
			crc_nxt = stepped; // [R8] [R9]
		end
	end

	// Register update
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			crc_r <= CRC_RESET_VAL; // [R11]
			seq_r <= CRCG_SEQ_DATA;
		end else begin
			crc_r <= crc_nxt;
			seq_r <= seq_nxt;
		end
	end

	// Read ports mirror the result register
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			crc_high_byte_port <= hi_half(CRC_RESET_VAL);
			crc_low_byte_port <= lo_half(CRC_RESET_VAL);
		end else begin
			crc_high_byte_port <= hi_half(crc_nxt); // [R10]
			crc_low_byte_port <= lo_half(crc_nxt); // [R10]
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	property p_seed_hi;
		@(posedge clk_sys) disable iff (!rstn)
		do_hi |=> crc_high_byte_port == $past(wr_data);
	endproperty
	a_seed_hi: assert property (p_seed_hi) // [R7]
		else $error("high seed byte not loaded");

	property p_seed_lo;
		@(posedge clk_sys) disable iff (!rstn)
		do_hi ##1 (do_seed_lo && !deep_stop) |=>
			crc_low_byte_port == $past(wr_data) &&
			$stable(crc_high_byte_port);
	endproperty
	a_seed_lo: assert property (p_seed_lo) // [R7]
		else $error("low seed byte not loaded");

	property p_data_shift;
		@(posedge clk_sys) disable iff (!rstn)
		do_data |=> crc_r == $past(stepped);
	endproperty
	a_data_shift: assert property (p_data_shift) // [R8]
		else $error("data byte not shifted");

	property p_ports_track;
		@(posedge clk_sys) disable iff (!rstn)
		##1 {crc_high_byte_port, crc_low_byte_port} == crc_r;
	endproperty
	a_ports_track: assert property (p_ports_track) // [R10]
		else $error("read ports differ from result");

	property p_freeze;
		@(posedge clk_sys) disable iff (!rstn)
		frozen |=> $stable(crc_r) && $stable(seq_r);
	endproperty
	a_freeze: assert property (p_freeze) // [R6]
		else $error("state changed in light stop");

	property p_deep;
		@(posedge clk_sys) disable iff (!rstn)
		deep_stop |=> crc_r == CRC_RESET_VAL &&
			seq_r == CRCG_SEQ_DATA;
	endproperty
	a_deep: assert property (p_deep) // [R5]
		else $error("deep stop did not reset");

	property p_wait_works;
		@(posedge clk_sys) disable iff (!rstn)
		(pmode == CRCG_WAIT && wr_high) |=>
			seq_r == CRCG_SEQ_SEED_LO;
	endproperty
	a_wait_works: assert property (p_wait_works) // [R4]
		else $error("wait mode ignored a write");

	property p_seed_one_shot;
		@(posedge clk_sys) disable iff (!rstn)
		do_seed_lo |=> seq_r == CRCG_SEQ_DATA;
	endproperty
	a_seed_one_shot: assert property (p_seed_one_shot) // [R11]
		else $error("seed sequencing stuck");

	property p_hi_wins;
		@(posedge clk_sys) disable iff (!rstn)
		(active && wr_high && wr_low) |=>
			seq_r == CRCG_SEQ_SEED_LO &&
			crc_high_byte_port == $past(wr_data);
	endproperty
	a_hi_wins: assert property (p_hi_wins) // [R7]
		else $error("low write not dropped under high write");

	property p_hi_keeps_lo;
		@(posedge clk_sys) disable iff (!rstn)
		do_hi |=> crc_low_byte_port == $past(crc_low_byte_port);
	endproperty
	a_hi_keeps_lo: assert property (p_hi_keeps_lo) // [R7]
		else $error("high seed write disturbed low byte");

	property p_reset_state;
		@(posedge clk_sys)
		!rstn |=> crc_r == CRC_RESET_VAL &&
			seq_r == CRCG_SEQ_DATA &&
			crc_high_byte_port == hi_half(CRC_RESET_VAL) &&
			crc_low_byte_port == lo_half(CRC_RESET_VAL);
	endproperty
	a_reset_state: assert property (p_reset_state) // [R11]
		else $error("reset did not clear the generator");

	property p_idle_hold;
		@(posedge clk_sys) disable iff (!rstn)
		(!wr_high && !wr_low && !deep_stop) |=>
			$stable(crc_r) && $stable(seq_r);
	endproperty
	a_idle_hold: assert property (p_idle_hold) // [R10]
		else $error("result changed without a write");

	property p_wait_data;
		@(posedge clk_sys) disable iff (!rstn)
		(pmode == CRCG_WAIT && do_data) |=>
			crc_r == $past(stepped);
	endproperty
	a_wait_data: assert property (p_wait_data) // [R4]
		else $error("wait mode ignored a data byte");

	c_seed_then_data: cover property (@(posedge clk_sys)
		do_hi ##1 do_seed_lo ##1 do_data);
	c_back_to_back: cover property (@(posedge clk_sys)
		do_data ##1 do_data);
	c_freeze_resume: cover property (@(posedge clk_sys)
		frozen ##1 !frozen ##0 do_data);
	c_wait_data: cover property (@(posedge clk_sys)
		pmode == CRCG_WAIT && do_data);
endmodule

// ==== include/crcg_pkg.sv ====
// Purpose: Shared constants for the 16-bit CRC generator
// Assumes: Byte-wide processor writes, one clock domain
// Notes: Polynomial x^16 + x^12 + x^5 + 1
package crcg_pkg;
	localparam int CRC_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_RESET_VAL = 16'h0000;
	localparam int HI_LSB = 8;
	localparam int LO_LSB = 0;
	// Power modes seen by the generator
	typedef enum logic [1:0] {
		CRCG_RUN = 2'b00,
		CRCG_WAIT = 2'b01,
		CRCG_STOP_DEEP = 2'b10,
		CRCG_STOP_LIGHT = 2'b11
	} crcg_pmode_t;
	// Seed sequencing states
	typedef enum logic [0:0] {
		CRCG_SEQ_DATA = 1'b0,
		CRCG_SEQ_SEED_LO = 1'b1
	} crcg_seq_t;
endpackage

// ==== sim/tb_crcg_top.sv ====
// Purpose: Self-checking bench for the CRC16 generator
// Assumes: One write or idle cycle per clock, checked every cycle
// Notes: Reference model tracks seeding, power modes and shifting
`timescale 1ns/1ns
module tb_crcg_top;
	import crcg_pkg::*;
	// ****************************************
	// Signals and model state
	// ****************************************
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	crcg_pmode_t pmode = CRCG_RUN;
	logic wr_high = 1'b0;
	logic wr_low = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] crc_high_byte_port;
	logic [7:0] crc_low_byte_port;
	wire [15:0] result_seen = {crc_high_byte_port, crc_low_byte_port};
	logic [15:0] exp_r = 16'h0000;
	logic seq_r = 1'b0;
	integer seed = 32'heb8f;
	integer r;
	int n_errors = 0;
	int n_compared = 0;
	always #20 clk_sys = ~clk_sys;
	crcg_top uut (.clk_sys(clk_sys), .rstn(rstn), .pmode(pmode),
		.wr_high(wr_high), .wr_low(wr_low), .wr_data(wr_data),
		.crc_high_byte_port(crc_high_byte_port),
		.crc_low_byte_port(crc_low_byte_port));
	// ****************************************
	// Model and checking
	// ****************************************
	// Eight message bits in, most significant first
	function automatic logic [15:0] step(logic [15:0] c, logic [7:0] b);
		logic fb;
		for (int i = 7; i >= 0; i--) begin
			fb = c[15] ^ b[i];
			c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		return c;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED result exp %h seen %h", exp, seen);
		end
	endtask
	// Drive one cycle, check previous cycle's effect, then model this one
	task automatic cyc(input logic h, l, input logic [7:0] d,
		input crcg_pmode_t pm);
		@(posedge clk_sys);
		wr_high <= h;
		wr_low <= l;
		wr_data <= d;
		pmode <= pm;
		#1;
		chk(result_seen, exp_r);
		if (pm == CRCG_STOP_DEEP) begin
			exp_r = 16'h0000;
			seq_r = 1'b0;
		end else if (pm == CRCG_STOP_LIGHT) begin
			exp_r = exp_r;
		end else if (h) begin
			exp_r[15:8] = d;
			seq_r = 1'b1;
		end else if (l && seq_r) begin
			exp_r[7:0] = d;
			seq_r = 1'b0;
		end else if (l) begin
			exp_r = step(exp_r, d);
		end
	endtask
	// Mid-run reset: check the last write, then the cleared state
	task automatic reset_pulse;
		@(posedge clk_sys);
		rstn <= 1'b0;
		wr_high <= 1'b0;
		wr_low <= 1'b0;
		#1;
		chk(result_seen, exp_r);
		@(posedge clk_sys);
		rstn <= 1'b1;
		#1;
		chk(result_seen, 16'h0000);
		exp_r = 16'h0000;
		seq_r = 1'b0;
	endtask
	task automatic test_done;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ****************************************
	// Stimulus
	// ****************************************
	initial begin
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		cyc(0, 1, 8'h5a, CRCG_RUN);
		cyc(1, 0, 8'hff, CRCG_RUN);
		cyc(0, 1, 8'hff, CRCG_WAIT);
		cyc(0, 1, 8'h41, CRCG_RUN);
		cyc(0, 0, 8'h00, CRCG_RUN);
		chk(result_seen, 16'hb915);
		cyc(1, 1, 8'h12, CRCG_RUN);
		cyc(0, 1, 8'h34, CRCG_STOP_LIGHT);
		cyc(0, 1, 8'h34, CRCG_RUN);
		cyc(0, 1, 8'h77, CRCG_RUN);
		cyc(0, 0, 8'h00, CRCG_STOP_DEEP);
		cyc(0, 1, 8'h09, CRCG_RUN);
		// Reset after a high write drops the pending seed half
		cyc(1, 0, 8'hab, CRCG_RUN);
		reset_pulse();
		cyc(0, 1, 8'h5b, CRCG_RUN);
		cyc(0, 0, 8'h00, CRCG_RUN);
		// One flipped message bit gives a different result
		chk(16'(result_seen == step(16'h0000, 8'h5a)), 16'h0000);
		// Random traffic, mostly run mode, strobes back to back
		repeat (400) begin
			r = $random(seed);
			cyc(r[9:7] == 3'h0, r[6], r[15:8],
				crcg_pmode_t'(r[5:4] == 2'h0 ? r[1:0] : 2'h0));
		end
		cyc(0, 0, 8'h00, CRCG_RUN);
		test_done();
	end
	// Watchdog well past the expected run length
	initial begin
		#(2000 * 40);
		n_errors++;
		test_done();
	end
endmodule
